// *** design/uart_modem_ctrl_line_status.v ***
/*
 One UART channel: modem control, line status, line control,
 transmitter, receive FIFO with per-character error flags, and an
 AXI4-Lite register slave. Assumes serial and modem inputs are
 synchronous to clock_i and a single outstanding access per channel.
*/
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
`include "umc_consts.vh"
module uart_modem_ctrl_line_status #(
  parameter FIFO_AW = 8
) (
  input wire clock_i,
  input wire sys_rst_i,
  input wire [7:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [7:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire rxd_i,
  input wire cts_n_i,
  input wire dsr_n_i,
  input wire dcd_n_i,
  input wire ri_n_i,
  output reg txd_o,
  output reg rts_n_o,
  output reg dtr_n_o,
  output reg channel_irq_out_o,
  output reg xon_any_en_o,
  output reg xoff_resend_en_o,
  output reg [1:0] reg_page_o
);
  localparam [FIFO_AW:0] DEPTH = {1'b1, {FIFO_AW{1'b0}}};
  localparam [FIFO_AW:0] ONE = {{FIFO_AW{1'b0}}, 1'b1};

  reg [7:0] modem_control_q;
  reg [7:0] line_control_q;
  reg [7:0] irq_en_q;
  reg [7:0] fifo_ctrl_q;
  reg [15:0] divisor_q;
  reg aw_rdy_q;
  reg w_rdy_q;
  reg ar_rdy_q;
  reg aw_hold_q;
  reg w_hold_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  wire loop = modem_control_q[`UMC_MC_LOOP];
  assign s_axi_awready_o = aw_rdy_q;
  assign s_axi_wready_o = w_rdy_q;
  assign s_axi_arready_o = ar_rdy_q;

  // Prescaler and baud tick
  reg [1:0] pre_cnt_q;
  reg [15:0] baud_cnt_q;
  reg tick_q;
  wire pre_en = modem_control_q[`UMC_MC_PRESCALE] ? (pre_cnt_q == `UMC_PRESC_LAST) : 1'b1;
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      pre_cnt_q <= 2'h0;
      baud_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 2'h1;
      tick_q <= 1'b0;
      if (pre_en) begin
        // Divisor of zero behaves as one
        if (baud_cnt_q + 16'h0001 >= divisor_q) begin
          baud_cnt_q <= 16'h0000;
          tick_q <= 1'b1;
        end else begin
          baud_cnt_q <= baud_cnt_q + 16'h0001;
        end
      end
    end
  end

  // Transmitter
  reg [7:0] thr_q;
  reg thr_full_q;
  reg tx_busy_q;
  reg [11:0] tx_sh_q;
  reg [3:0] tx_bits_q;
  reg [3:0] tx_ph_q;
  wire [1:0] wl = line_control_q[1:0];
  // Four-bit sum, so an 8-bit word does not wrap to zero
  wire [3:0] wbits = {2'b00, wl} + 4'd5;
  wire [7:0] thr_m = thr_q & ~(8'hff << wbits);
  wire tx_par = line_control_q[5] ? ~line_control_q[4] :
                (line_control_q[4] ? ^thr_m : ~^thr_m);
  // Start and first stop bit both counted, so back-to-back frames keep a stop
  wire [3:0] tx_len = 4'd7 + {2'b00, wl} + {3'b000, line_control_q[3]} +
                      {3'b000, line_control_q[2]};
  reg [11:0] frame;
  always @* begin
    // Unused data slots carry the stop level
    frame = {{3{1'b1}}, thr_m | (8'hff << wbits), 1'b0};
    if (line_control_q[3]) begin
      frame[4'd6 + {2'b00, wl}] = tx_par;
    end
  end
  wire tx_load = thr_full_q & ~tx_busy_q;
  wire tx_line = tx_busy_q ? tx_sh_q[0] : 1'b1;

  // Receiver and FIFO
  wire rx_valid;
  wire [7:0] rx_data;
  wire rx_pe;
  wire rx_fe;
  wire rx_bi;
  wire rx_in = loop ? tx_line : rxd_i;
  umc_rx u_rx (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .tick_i(tick_q),
    .rx_i(rx_in),
    .word_len_i(wl),
    .parity_sel_i(line_control_q[5:3]),
    .valid_o(rx_valid),
    .data_o(rx_data),
    .pe_o(rx_pe),
    .fe_o(rx_fe),
    .bi_o(rx_bi)
  );

  reg [10:0] fifo_mem [0:(1<<FIFO_AW)-1];
  reg [FIFO_AW-1:0] wr_ptr_q;
  reg [FIFO_AW-1:0] rd_ptr_q;
  reg [FIFO_AW:0] count_q;
  reg [FIFO_AW:0] err_cnt_q;
  reg overrun_q;
  wire [10:0] head = fifo_mem[rd_ptr_q];
  wire has_data = (count_q != {(FIFO_AW+1){1'b0}});
  wire [FIFO_AW:0] limit = fifo_ctrl_q[`UMC_FC_EN] ? DEPTH : ONE;
  wire rx_err = rx_pe | rx_fe | rx_bi;
  wire push = rx_valid & (count_q < limit);

  // Register read decode
  wire rd_go = s_axi_arvalid_i & ar_rdy_q;
  reg [7:0] rd_val;
  reg rd_bad;
  wire [7:0] lsr_val = {err_cnt_q != {(FIFO_AW+1){1'b0}},
                        ~thr_full_q & ~tx_busy_q, ~thr_full_q,
                        has_data ? head[10:8] : 3'b000, overrun_q, has_data};
  wire [3:0] msr_hi = loop ? ~{modem_control_q[`UMC_MC_AUX_OUTPUT_TWO], modem_control_q[`UMC_MC_AUX_OUTPUT_ONE],
                               modem_control_q[`UMC_MC_DTR], modem_control_q[`UMC_MC_RTS]}
                           : ~{dcd_n_i, ri_n_i, dsr_n_i, cts_n_i};
  always @* begin
    rd_val = 8'h00;
    rd_bad = 1'b0;
    if (s_axi_araddr_i == `UMC_OFS_MODEM_CTRL) begin
      rd_val = modem_control_q;
    end else if (s_axi_araddr_i == `UMC_OFS_LINE_STATUS) begin
      rd_val = lsr_val;
    end else if (s_axi_araddr_i == `UMC_OFS_LINE_CTRL) begin
      rd_val = line_control_q;
    end else if (s_axi_araddr_i == `UMC_OFS_MODEM_STATUS) begin
      rd_val = {msr_hi, 4'h0};
    end else if (s_axi_araddr_i == `UMC_OFS_DATA) begin
      rd_val = has_data ? head[7:0] : 8'h00;
    end else if (s_axi_araddr_i == `UMC_OFS_IRQ_EN) begin
      rd_val = irq_en_q;
    end else if (s_axi_araddr_i == `UMC_OFS_FIFO_CTRL) begin
      rd_val = fifo_ctrl_q;
    end else if (s_axi_araddr_i == `UMC_OFS_DIVISOR) begin
      rd_val = divisor_q[7:0];
    end else begin
      rd_bad = 1'b1;
    end
  end
  wire [31:0] rd_word = (s_axi_araddr_i == `UMC_OFS_DIVISOR) ?
                        {16'h0000, divisor_q} : {24'h00_0000, rd_val};
  wire pop = rd_go & (s_axi_araddr_i == `UMC_OFS_DATA) & has_data;
  wire lsr_rd = rd_go & (s_axi_araddr_i == `UMC_OFS_LINE_STATUS);

  // Register write
  wire wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid_o;
  wire wr_ok = (awaddr_q[1:0] == 2'b00) & (awaddr_q <= `UMC_OFS_DIVISOR) &
               (awaddr_q != `UMC_OFS_LINE_STATUS) & (awaddr_q != `UMC_OFS_MODEM_STATUS);
  wire wr_b0 = wr_go & wstrb_q[0];
  wire thr_wr = wr_b0 & (awaddr_q == `UMC_OFS_DATA);
  wire rx_rst = wr_b0 & (awaddr_q == `UMC_OFS_FIFO_CTRL) & wdata_q[`UMC_FC_RXRST];
  wire tx_rst = wr_b0 & (awaddr_q == `UMC_OFS_FIFO_CTRL) & wdata_q[`UMC_FC_TXRST];

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      aw_rdy_q <= 1'b1;
      w_rdy_q <= 1'b1;
      ar_rdy_q <= 1'b1;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `UMC_RESP_OK;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o <= `UMC_RESP_OK;
      s_axi_rdata_o <= 32'h0000_0000;
      modem_control_q <= `UMC_MC_RST;
      line_control_q <= `UMC_LC_RST;
      irq_en_q <= `UMC_IE_RST;
      fifo_ctrl_q <= `UMC_FC_RST;
      divisor_q <= `UMC_DIV_RST;
    end else begin
      if (s_axi_awvalid_i && aw_rdy_q) begin
        aw_rdy_q <= 1'b0;
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && w_rdy_q) begin
        w_rdy_q <= 1'b0;
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_ok ? `UMC_RESP_OK : `UMC_RESP_SLVERR;
        if (wstrb_q[0]) begin
          if (awaddr_q == `UMC_OFS_MODEM_CTRL) begin
            modem_control_q <= wdata_q[7:0];
          end else if (awaddr_q == `UMC_OFS_LINE_CTRL) begin
            line_control_q <= wdata_q[7:0];
          end else if (awaddr_q == `UMC_OFS_IRQ_EN) begin
            irq_en_q <= wdata_q[7:0];
          end else if (awaddr_q == `UMC_OFS_FIFO_CTRL) begin
            // Reset bits are self-clearing
            fifo_ctrl_q <= {7'h00, wdata_q[`UMC_FC_EN]};
          end else if (awaddr_q == `UMC_OFS_DIVISOR) begin
            divisor_q[7:0] <= wdata_q[7:0];
          end
        end
        if (wstrb_q[1] && awaddr_q == `UMC_OFS_DIVISOR) begin
          divisor_q[15:8] <= wdata_q[15:8];
        end
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        aw_rdy_q <= 1'b1;
        w_rdy_q <= 1'b1;
      end
      if (rd_go) begin
        ar_rdy_q <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= rd_word;
        s_axi_rresp_o <= rd_bad ? `UMC_RESP_SLVERR : `UMC_RESP_OK;
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        ar_rdy_q <= 1'b1;
      end
    end
  end

  // Transmit path
  always @(posedge clock_i) begin
    if (sys_rst_i || tx_rst) begin
      thr_q <= 8'h00;
      thr_full_q <= 1'b0;
      tx_busy_q <= 1'b0;
      tx_sh_q <= 12'hfff;
      tx_bits_q <= 4'h0;
      tx_ph_q <= 4'h0;
    end else begin
      if (thr_wr) begin
        thr_q <= wdata_q[7:0];
        thr_full_q <= 1'b1;
      end else if (tx_load) begin
        thr_full_q <= 1'b0;
      end
      if (tx_load) begin
        tx_busy_q <= 1'b1;
        tx_sh_q <= frame;
        tx_bits_q <= tx_len;
        tx_ph_q <= 4'h0;
      end else if (tx_busy_q && tick_q) begin
        tx_ph_q <= tx_ph_q + 4'h1;
        if (tx_ph_q == `UMC_OVS_LAST) begin
          tx_sh_q <= {1'b1, tx_sh_q[11:1]};
          tx_bits_q <= tx_bits_q - 4'h1;
          if (tx_bits_q == 4'h1) begin
            tx_busy_q <= 1'b0;
          end
        end
      end
    end
  end

  // Receive FIFO
  always @(posedge clock_i) begin
    if (push) begin
      fifo_mem[wr_ptr_q] <= {rx_bi, rx_fe, rx_pe, rx_data};
    end
  end
  always @(posedge clock_i) begin
    if (sys_rst_i || rx_rst) begin
      wr_ptr_q <= {FIFO_AW{1'b0}};
      rd_ptr_q <= {FIFO_AW{1'b0}};
      count_q <= {(FIFO_AW+1){1'b0}};
      err_cnt_q <= {(FIFO_AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + ONE[FIFO_AW-1:0];
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + ONE[FIFO_AW-1:0];
      end
      if (push && !pop) begin
        count_q <= count_q + ONE;
      end else if (pop && !push) begin
        count_q <= count_q - ONE;
      end
      if ((push && rx_err) && !(pop && head[10:8] != 3'b000)) begin
        err_cnt_q <= err_cnt_q + ONE;
      end else if (!(push && rx_err) && (pop && head[10:8] != 3'b000)) begin
        err_cnt_q <= err_cnt_q - ONE;
      end
    end
  end
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      overrun_q <= 1'b0;
    end else if (rx_valid && !push) begin
      overrun_q <= 1'b1;
    end else if (lsr_rd) begin
      overrun_q <= 1'b0;
    end
  end

  // Pin and control outputs, all registered
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      txd_o <= 1'b1;
      rts_n_o <= 1'b1;
      dtr_n_o <= 1'b1;
      channel_irq_out_o <= 1'b0;
      xon_any_en_o <= 1'b0;
      xoff_resend_en_o <= 1'b0;
      reg_page_o <= `UMC_PAGE0;
    end else begin
      txd_o <= loop | (tx_line & ~line_control_q[`UMC_LC_BREAK]);
      rts_n_o <= loop | ~modem_control_q[`UMC_MC_RTS];
      dtr_n_o <= loop | ~modem_control_q[`UMC_MC_DTR];
      channel_irq_out_o <= modem_control_q[`UMC_MC_AUX_OUTPUT_TWO] &
                           ((irq_en_q[`UMC_IE_THRE] & ~thr_full_q) |
                            (irq_en_q[`UMC_IE_RDA] & has_data));
      xon_any_en_o <= modem_control_q[`UMC_MC_XON_ANY];
      xoff_resend_en_o <= modem_control_q[`UMC_MC_PAGE2] & modem_control_q[`UMC_MC_AUX_OUTPUT_ONE];
      if (line_control_q[`UMC_LC_DLAB]) begin
        reg_page_o <= `UMC_PAGE1;
      end else if (modem_control_q[`UMC_MC_PAGE2]) begin
        reg_page_o <= `UMC_PAGE2;
      end else begin
        reg_page_o <= `UMC_PAGE0;
      end
    end
  end
endmodule

// *** design/umc_rx.v ***
/*
 Serial receiver with 16x oversampling, word length 5 to 8,
 parity check and break detection. Assumes tick_i is a one-cycle
 enable at sixteen times the bit rate and rx_i is synchronous.
*/
`timescale 1ns/10ps
`include "umc_consts.vh"
module umc_rx (
  input wire clock_i,
  input wire sys_rst_i,
  input wire tick_i,
  input wire rx_i,
  input wire [1:0] word_len_i,
  input wire [2:0] parity_sel_i,
  output reg valid_o,
  output reg [7:0] data_o,
  output reg pe_o,
  output reg fe_o,
  output reg bi_o
);
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_START = 3'd1;
  localparam [2:0] ST_DATA = 3'd2;
  localparam [2:0] ST_PAR = 3'd3;
  localparam [2:0] ST_STOP = 3'd4;
  localparam [2:0] ST_HOLD = 3'd5;

  reg [2:0] state_q;
  reg [3:0] ph_q;
  reg [2:0] bit_q;
  reg [7:0] sh_q;
  reg par_q;
  wire [7:0] dat = sh_q >> (2'd3 - word_len_i);
  wire par_exp = parity_sel_i[2] ? ~parity_sel_i[1] :
                 (parity_sel_i[1] ? ^dat : ~^dat);

  always @(posedge clock_i) begin
    valid_o <= 1'b0;
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      ph_q <= 4'h0;
      bit_q <= 3'd0;
      sh_q <= 8'h00;
      par_q <= 1'b0;
      data_o <= 8'h00;
      pe_o <= 1'b0;
      fe_o <= 1'b0;
      bi_o <= 1'b0;
    end else if (tick_i) begin
      ph_q <= ph_q + 4'h1;
      case (state_q)
        ST_IDLE: begin
          ph_q <= 4'h0;
          if (!rx_i) begin
            state_q <= ST_START;
          end
        end
        ST_START: begin
          if (ph_q == `UMC_OVS_MID) begin
            ph_q <= 4'h0;
            bit_q <= 3'd0;
            state_q <= rx_i ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (ph_q == `UMC_OVS_LAST) begin
            sh_q <= {rx_i, sh_q[7:1]};
            bit_q <= bit_q + 3'd1;
            if (bit_q == {1'b1, word_len_i}) begin
              state_q <= parity_sel_i[0] ? ST_PAR : ST_STOP;
            end
          end
        end
        ST_PAR: begin
          if (ph_q == `UMC_OVS_LAST) begin
            par_q <= rx_i;
            state_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (ph_q == `UMC_OVS_LAST) begin
            valid_o <= 1'b1;
            data_o <= dat;
            pe_o <= parity_sel_i[0] & (par_q != par_exp);
            fe_o <= ~rx_i;
            bi_o <= ~rx_i & (dat == 8'h00) & ~(parity_sel_i[0] & par_q);
            if (!parity_sel_i[0]) begin
              par_q <= 1'b0;
            end
            state_q <= rx_i ? ST_IDLE : ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (rx_i) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// *** inc/umc_consts.vh ***
/*
 Constants for the channel modem control and line status block:
 register offsets, bit positions, reset values and small counts.
 Assumes a 32-bit AXI4-Lite slave with byte addresses.
*/
`ifndef UMC_CONSTS_VH
`define UMC_CONSTS_VH

`define UMC_OFS_MODEM_CTRL 8'h00
`define UMC_OFS_LINE_STATUS 8'h04
`define UMC_OFS_LINE_CTRL 8'h08
`define UMC_OFS_MODEM_STATUS 8'h0c
`define UMC_OFS_DATA 8'h10
`define UMC_OFS_IRQ_EN 8'h14
`define UMC_OFS_FIFO_CTRL 8'h18
`define UMC_OFS_DIVISOR 8'h1c

`define UMC_MC_PRESCALE 7
`define UMC_MC_PAGE2 6
`define UMC_MC_XON_ANY 5
`define UMC_MC_LOOP 4
`define UMC_MC_AUX_OUTPUT_TWO 3
`define UMC_MC_AUX_OUTPUT_ONE 2
`define UMC_MC_RTS 1
`define UMC_MC_DTR 0
`define UMC_LC_DLAB 7
`define UMC_LC_BREAK 6
`define UMC_IE_RDA 0
`define UMC_IE_THRE 1
`define UMC_FC_EN 0
`define UMC_FC_RXRST 1
`define UMC_FC_TXRST 2

`define UMC_MC_RST 8'h00
`define UMC_LC_RST 8'h00
`define UMC_IE_RST 8'h00
`define UMC_FC_RST 8'h00
`define UMC_DIV_RST 16'h0001

`define UMC_PRESC_LAST 2'h3
`define UMC_OVS_LAST 4'hf
`define UMC_OVS_MID 4'h7
`define UMC_RESP_OK 2'b00
`define UMC_RESP_SLVERR 2'b10
`define UMC_PAGE0 2'h0
`define UMC_PAGE1 2'h1
`define UMC_PAGE2 2'h2

`endif

// *** sim/tb.sv ***
/*
 Testbench for the channel: bus tasks, modem partner, self checks.
 Assumes divisor 1 and a small receive FIFO.
*/
`timescale 1ns/10ps
module tb;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, page;
  logic rxd, cts_n, dsr_n, dcd_n, ri_n, txd, rts_n, dtr_n, irq, xon, resend;
  int err_total = 0;
  int n_tests = 0;
  logic [3:0] lp [4] = '{4'h0, 4'hf, 4'h5, 4'ha};

  uart_modem_ctrl_line_status #(.FIFO_AW(4)) uut (.clock_i(clk), .sys_rst_i(rst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .rxd_i(rxd), .cts_n_i(cts_n),
    .dsr_n_i(dsr_n), .dcd_n_i(dcd_n), .ri_n_i(ri_n), .txd_o(txd), .rts_n_o(rts_n),
    .dtr_n_o(dtr_n), .channel_irq_out_o(irq), .xon_any_en_o(xon),
    .xoff_resend_en_o(resend), .reg_page_o(page));
  umc_modem_model modem (.clock_i(clk), .txd_i(txd), .rts_n_i(rts_n), .dtr_n_i(dtr_n),
    .rxd_o(rxd), .cts_n_o(cts_n), .dsr_n_o(dsr_n), .dcd_n_o(dcd_n), .ri_n_o(ri_n));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_pin(input logic g, input logic e);
    chk_data({31'h0, g}, {31'h0, e});
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Address and data offered together; readies held until the answer
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1));
    chk_data({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1));
    d = rdata;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic lsr_is(input logic [7:0] e);
    rd(8'h04, v);
    chk_data(v, {24'h00_0000, e});
  endtask

  task automatic rb_is(input logic [7:0] e);
    rd(8'h10, v);
    chk_data(v, {24'h00_0000, e});
  endtask

  initial begin
    #(8 * 20000);
    err_total++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h00, v); chk_data(v, 32'h0000_0000);
    lsr_is(8'h60);
    chk_pin(rts_n, 1'b1);
    chk_pin(dtr_n, 1'b1);
    chk_pin(irq, 1'b0);
    rd(8'h0c, v); chk_data(v, 32'h0000_0090);
    rd(8'h20, v); chk_data({30'h0, rresp}, 32'h0000_0002);
    wr(8'h04, 8'hff, 2'b10);
    lsr_is(8'h60);
    $display("test reset done");
    wr(8'h00, 8'h03, 2'b00);
    chk_pin(rts_n, 1'b0);
    chk_pin(dtr_n, 1'b0);
    wr(8'h00, 8'h04, 2'b00);
    chk_pin(resend, 1'b0);
    wr(8'h00, 8'h64, 2'b00);
    chk_pin(resend, 1'b1);
    chk_pin(xon, 1'b1);
    chk_data({30'h0, page}, 32'h0000_0002);
    wr(8'h08, 8'h80, 2'b00);
    chk_data({30'h0, page}, 32'h0000_0001);
    $display("test control done");
    foreach (lp[i]) begin
      wr(8'h00, {4'h1, lp[i]}, 2'b00);
      rd(8'h0c, v); chk_data(v, {24'h0, ~lp[i][3], ~lp[i][2], ~lp[i][0], ~lp[i][1], 4'h0});
      chk_pin(rts_n & dtr_n, 1'b1);
    end
    wr(8'h08, 8'h03, 2'b00);
    wr(8'h10, 8'h5a, 2'b00);
    chk_pin(txd, 1'b1);
    rd(8'h04, v); chk_data(v & 32'h0000_0040, 32'h0000_0000);
    repeat (250) @(posedge clk);
    lsr_is(8'h61);
    rb_is(8'h5a);
    wr(8'h00, 8'h90, 2'b00);
    wr(8'h10, 8'ha5, 2'b00);
    repeat (250) @(posedge clk);
    rd(8'h04, v); chk_data(v & 32'h0000_0001, 32'h0000_0000);
    repeat (500) @(posedge clk);
    rb_is(8'ha5);
    $display("test loopback done");
    wr(8'h00, 8'h00, 2'b00);
    wr(8'h14, 8'h02, 2'b00);
    chk_pin(irq, 1'b0);
    wr(8'h00, 8'h08, 2'b00);
    chk_pin(irq, 1'b1);
    wr(8'h14, 8'h00, 2'b00);
    chk_pin(irq, 1'b0);
    $display("test interrupt done");
    wr(8'h18, 8'h01, 2'b00);
    wr(8'h08, 8'h0b, 2'b00);
    modem.send_frame(8'ha5, 1'b1, 1'b1);
    wr(8'h08, 8'h1b, 2'b00);
    modem.send_frame(8'h3c, 1'b1, 1'b1);
    modem.send_frame(8'h11, 1'b0, 1'b0);
    repeat (4) @(posedge clk);
    lsr_is(8'he1);
    lsr_is(8'he1);
    rb_is(8'ha5);
    lsr_is(8'he5);
    rb_is(8'h3c);
    lsr_is(8'he9);
    rb_is(8'h11);
    lsr_is(8'h60);
    modem.send_break();
    rd(8'h04, v); chk_data(v & 32'h0000_0091, 32'h0000_0091);
    rb_is(8'h00);
    rd(8'h04, v); chk_data(v & 32'h0000_0081, 32'h0000_0000);
    $display("test receive done");
    wr(8'h18, 8'h00, 2'b00);
    wr(8'h08, 8'h0b, 2'b00);
    modem.send_frame(8'h5a, 1'b1, 1'b1);
    modem.send_frame(8'h5b, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    lsr_is(8'h63);
    rb_is(8'h5a);
    lsr_is(8'h60);
    $display("test overrun done");
    complete_run();
  end
endmodule

// *** sim/umc_checker.sv ***
/*
 Checker for the channel modem control and line status block.
 Assumes it is bound to the channel top and that the bus carries
 byte addresses with the control byte in lane 0.
*/
`timescale 1ns/10ps
module umc_checker (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic txd_o,
  input wire logic rts_n_o,
  input wire logic dtr_n_o,
  input wire logic channel_irq_out_o,
  input wire logic xon_any_en_o,
  input wire logic xoff_resend_en_o,
  input wire logic [1:0] reg_page_o
);
  logic [7:0] aw_q, ar_q, wd_q, mc_q, lc_q;
  logic ws_q, bv_q;
  wire wr_ok = s_axi_bvalid_o && !bv_q && s_axi_bresp_o == 2'b00 && ws_q;

  // Shadow copies; outputs may differ only while a response is pending
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      aw_q <= 8'h00;
      ar_q <= 8'h00;
      wd_q <= 8'h00;
      ws_q <= 1'b0;
      bv_q <= 1'b0;
      mc_q <= 8'h00;
      lc_q <= 8'h00;
    end else begin
      bv_q <= s_axi_bvalid_o;
      if (s_axi_awvalid_i && s_axi_awready_o) aw_q <= s_axi_awaddr_i;
      if (s_axi_arvalid_i && s_axi_arready_o) ar_q <= s_axi_araddr_i;
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        wd_q <= s_axi_wdata_i[7:0];
        ws_q <= s_axi_wstrb_i[0];
      end
      if (wr_ok && aw_q == 8'h00) mc_q <= wd_q;
      if (wr_ok && aw_q == 8'h08) lc_q <= wd_q;
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  a_rts_drive: assert property (!s_axi_bvalid_o |-> rts_n_o == !(mc_q[1] && !mc_q[4]))
    else $error("request-to-send level disagrees with control");
  a_dtr_drive: assert property (wr_ok && aw_q == 8'h00 |=> dtr_n_o == !(wd_q[0] && !wd_q[4]))
    else $error("terminal-ready level disagrees with control");
  a_xon_any: assert property (!s_axi_bvalid_o |-> xon_any_en_o == mc_q[5])
    else $error("xon-any enable disagrees with control");
  a_resend_en: assert property (wr_ok && aw_q == 8'h00 |=> (xoff_resend_en_o == (wd_q[6] && wd_q[2]))[*2])
    else $error("resend enable disagrees with control");
  a_page_sel: assert property (!s_axi_bvalid_o |-> reg_page_o == (lc_q[7] ? 2'h1 : (mc_q[6] ? 2'h2 : 2'h0)))
    else $error("register page disagrees with control");
  a_irq_gate: assert property (!mc_q[3] && !s_axi_bvalid_o |-> !channel_irq_out_o)
    else $error("interrupt output active while disabled");
  a_loop_quiet: assert property (mc_q[4] && !s_axi_bvalid_o |-> txd_o && rts_n_o && dtr_n_o)
    else $error("line pins active during loopback");
  a_tx_empty: assert property ($rose(s_axi_rvalid_o) && ar_q == 8'h04 &&
    s_axi_rdata_o[6] |-> s_axi_rdata_o[5] && (txd_o || lc_q[6]))
    else $error("transmitter empty without holding empty or idle line");
  a_err_summary: assert property (s_axi_rvalid_o && ar_q == 8'h04 && s_axi_rdata_o[4:2] != 3'b000 |-> s_axi_rdata_o[7] && s_axi_rdata_o[0])
    else $error("head error without data or summary flag");
endmodule

bind uart_modem_ctrl_line_status umc_checker u_chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
  .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_araddr_i(s_axi_araddr_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o), .txd_o(txd_o),
  .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o), .channel_irq_out_o(channel_irq_out_o),
  .xon_any_en_o(xon_any_en_o), .xoff_resend_en_o(xoff_resend_en_o), .reg_page_o(reg_page_o));

// *** sim/umc_modem_model.sv ***
/*
 Behavioural modem on the serial side: fixed status pin levels and
 frame or break senders. Assumes divisor 1, so one bit is 16 clocks.
*/
`timescale 1ns/10ps
module umc_modem_model (
  input wire logic clock_i,
  input wire logic txd_i,
  input wire logic rts_n_i,
  input wire logic dtr_n_i,
  output logic rxd_o,
  output logic cts_n_o,
  output logic dsr_n_o,
  output logic dcd_n_o,
  output logic ri_n_o
);
  localparam int BIT_CYC = 16;

  // Mixed levels so status bits are told apart
  initial begin
    rxd_o = 1'b1;
    cts_n_o = 1'b0;
    dsr_n_o = 1'b1;
    dcd_n_o = 1'b0;
    ri_n_o = 1'b1;
  end

  // Start, eight data bits LSB first, parity, stop; then mark idle
  task automatic send_frame(input logic [7:0] d, input logic par, input logic stop);
    logic [10:0] fr;
    fr = {stop, par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd_o <= fr[i];
      repeat (BIT_CYC) @(posedge clock_i);
    end
    rxd_o <= 1'b1;
    @(posedge clock_i);
  endtask

  // Line held low well past a whole frame
  task automatic send_break();
    rxd_o <= 1'b0;
    repeat (BIT_CYC * 14) @(posedge clock_i);
    rxd_o <= 1'b1;
    repeat (BIT_CYC * 2) @(posedge clock_i);
  endtask
endmodule
